//--- inc/flsl_pkg.sv
// Constants, types and helpers for the flash status-lock and identify block
// Behaviour
// - Write-protect high disables lock, all bits writable
// - Lock clear or protect high: status write updates
// - Unlocked write sets lock and protect bits together
// - Identify opcode 90H or ABH, 24-bit address
// - Address 0 gives maker, 1 gives device code
// - Codes alternate until select rises
// - Protect low and locked: status write ignored
// - Protect low: lock only goes 0 to 1
// - Status write only directly after arm command
package flsl_pkg;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  typedef logic [ADDR_W-1:0] flsl_addr_t;
  typedef logic [DATA_W-1:0] flsl_data_t;
  typedef logic [7:0]        flsl_byte_t;

  // Register byte addresses
  localparam flsl_addr_t REG_STATUS     = 8'h00;
  localparam flsl_addr_t REG_ACCEPT_CNT = 8'h04;
  localparam flsl_addr_t REG_REJECT_CNT = 8'h08;

  // Field positions inside the serial status byte
  localparam int BP_LO_POS = 2;
  localparam int BP_HI_POS = 3;
  localparam int LOCK_POS  = 7;

  // Field positions inside the status register word
  localparam int ST_BP_LO_POS = 0;
  localparam int ST_BP_HI_POS = 1;
  localparam int ST_LOCK_POS  = 2;
  localparam int ST_ARM_POS   = 3;
  localparam int ST_WP_POS    = 4;
  localparam int ST_SEL_POS   = 5;

  // Reset values
  localparam logic           LOCK_RST = 1'b0;
  localparam logic     [1:0] BP_RST   = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // Identify opcodes, both accepted
  localparam flsl_byte_t OPC_IDENT_A = 8'h90;
  localparam flsl_byte_t OPC_IDENT_B = 8'hAB;

  // Bit counts of the serial frame
  localparam logic [5:0] OPC_LAST_BIT  = 6'h07;
  localparam logic [5:0] DATA_LAST_BIT = 6'h0F;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h1F;
  localparam logic [5:0] BIT_CNT_MAX   = 6'h3F;

  // Host power-up wait, kept for reference by the far side
  localparam int PU_WAIT_US = 10;
  localparam int CLK_MHZ    = 200;
  localparam int PU_WAIT_CYC = PU_WAIT_US * CLK_MHZ;

  // True for either identify opcode
  function automatic logic is_identify(input flsl_byte_t op);
    return (op == OPC_IDENT_A) || (op == OPC_IDENT_B);
  endfunction

endpackage

//--- hdl/flsl_sync2.sv
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
module flsl_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic d,
  output logic      q
);
  logic meta; // First stage, read only by the second

  // Two stages; reset drives a constant
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

//--- hdl/flsl_id_shifter.sv
// Serial output of the identification codes on the falling link clock
`timescale 1ns/1ps
module flsl_id_shifter
  import flsl_pkg::*;
(
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              id_active,
  input  wire logic              first_sel,
  input  wire flsl_pkg::flsl_byte_t mfr_code,
  input  wire flsl_pkg::flsl_byte_t dev_code,
  output logic                   so,
  output logic                   so_oe
);
  logic       started; // First byte loaded
  logic       sel;     // 0 maker code, 1 device code
  logic [2:0] bit_idx; // Next bit to drive
  wire  flsl_byte_t cur_byte = sel ? dev_code : mfr_code;
  wire  flsl_byte_t first_byte = first_sel ? dev_code : mfr_code;

  // Shift out on falling edge; select high ends and releases the pin
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      started <= 1'b0;
      sel     <= 1'b0;
      bit_idx <= 3'h7;
      so      <= 1'b0;
      so_oe   <= 1'b0;
    end else if (!id_active) begin
      // Still in opcode or address phase
      started <= 1'b0;
      so_oe   <= 1'b0;
    end else if (!started) begin
      // First byte, MSB first
      started <= 1'b1;
      sel     <= first_sel;
      bit_idx <= 3'h6;
      so      <= first_byte[7];
      so_oe   <= 1'b1;
    end else begin
      so <= cur_byte[bit_idx];
      if (bit_idx == 3'h0) begin
        // Byte done: swap code, run until select rises
        sel     <= ~sel;
        bit_idx <= 3'h7;
      end else begin
        bit_idx <= bit_idx - 3'h1;
      end
    end
  end
endmodule

//--- hdl/flsl_top.sv
// Status-write lock handling and identification read for a serial flash
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module flsl_top
  import flsl_pkg::*;
#(
  parameter flsl_byte_t MFR_CODE       = 8'h5A, // Arbitrary value
  parameter flsl_byte_t DEV_CODE       = 8'hC3, // Arbitrary value
  parameter flsl_byte_t OPC_STATUS_ARM = 8'h50,
  parameter flsl_byte_t OPC_STATUS_WR  = 8'h01
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire flsl_pkg::flsl_addr_t reg_addr,
  input  wire flsl_pkg::flsl_data_t reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output flsl_pkg::flsl_data_t      reg_rdata,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 si,
  input  wire logic                 wp_n_pin,
  output logic                      so,
  output logic                      so_oe,
  output logic                      protect_lock_bit,
  output logic                      block_protect_bit_lo,
  output logic                      block_protect_bit_hi
);

  // ------------------------------------------------------------------
  // Link clock domain: command capture
  // ------------------------------------------------------------------

  logic [5:0]  bit_cnt;      // Bits seen in this frame, saturating
  logic [6:0]  shift_in;     // Incoming bits, LSB newest
  logic        id_active;    // Address phase of identify done
  logic        first_sel;    // Address bit 0 of identify
  flsl_byte_t  opcode;       // Last complete opcode, quasi-static
  flsl_byte_t  data_byte;    // Byte after the opcode, quasi-static
  logic        got_data;     // Data byte arrived in the last frame
  logic        cmd_tgl = 1'b0; // Flips once per complete opcode

  wire flsl_byte_t in_byte  = {shift_in, si};              // Byte ending this edge
  wire             at_opc   = (bit_cnt == OPC_LAST_BIT);
  wire             at_data  = (bit_cnt == DATA_LAST_BIT);
  wire             at_addr  = (bit_cnt == ADDR_LAST_BIT);
  wire             cnt_full = (bit_cnt == BIT_CNT_MAX);

  // Frame-scoped state, cleared by select going high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt   <= 6'h00;
      shift_in  <= 7'h00;
      id_active <= 1'b0;
      first_sel <= 1'b0;
    end else begin
      shift_in <= in_byte[6:0];
      // Count bits, stopping at the top
      if (!cnt_full) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      // After 8 opcode and 24 address bits the codes start
      if (at_addr && is_identify(opcode)) begin
        id_active <= 1'b1;
        first_sel <= si;
      end
    end
  end

  // Frame results held for the system clock after select rises
  always_ff @(posedge sck) begin
    if (!cs_n && at_opc) begin
      // New command: record opcode, forget old data byte
      opcode   <= in_byte;
      got_data <= 1'b0;
      cmd_tgl  <= ~cmd_tgl;
    end else if (!cs_n && at_data) begin
      // First byte after opcode is the status value
      data_byte <= in_byte;
      got_data  <= 1'b1;
    end
  end

  // Identify code serialiser on the falling edge
  flsl_id_shifter u_shift (
    .sck       (sck),
    .cs_n      (cs_n),
    .id_active (id_active),
    .first_sel (first_sel),
    .mfr_code  (MFR_CODE),
    .dev_code  (DEV_CODE),
    .so        (so),
    .so_oe     (so_oe)
  );

  // ------------------------------------------------------------------
  // System clock domain: crossings
  // ------------------------------------------------------------------

  logic cs_s;    // Select, synchronised
  logic cs_d;    // Select, one cycle later
  logic wp_s;    // Write-protect pin, synchronised
  logic tgl_s;   // Command toggle, synchronised
  logic tgl_seen; // Toggle value already handled

  // Select pin into the system domain
  flsl_sync2 #(.RST_VAL(1'b1)) u_sync_cs (
    .clk  (clk),
    .srst (srst),
    .d    (cs_n),
    .q    (cs_s)
  );

  // Write-protect pin into the system domain
  flsl_sync2 #(.RST_VAL(1'b0)) u_sync_wp (
    .clk  (clk),
    .srst (srst),
    .d    (wp_n_pin),
    .q    (wp_s)
  );

  // Command toggle into the system domain
  flsl_sync2 #(.RST_VAL(1'b0)) u_sync_tgl (
    .clk  (clk),
    .srst (srst),
    .d    (cmd_tgl),
    .q    (tgl_s)
  );

  // ------------------------------------------------------------------
  // Command decode at the end of each frame
  // ------------------------------------------------------------------

  logic arm;       // Status write armed by previous command
  logic [CNT_W-1:0] accept_cnt; // Status writes applied
  logic [CNT_W-1:0] reject_cnt; // Status writes ignored

  wire frame_end  = cs_s & ~cs_d;             // Select rose
  wire new_cmd    = frame_end & (tgl_s != tgl_seen);
  wire is_arm     = (opcode == OPC_STATUS_ARM);
  wire is_swr     = (opcode == OPC_STATUS_WR) & got_data;
  // Protect pin high lifts the lock
  wire lock_off   = wp_s | ~protect_lock_bit;
  wire swr_do     = new_cmd & is_swr & arm & lock_off;
  wire swr_refuse = new_cmd & is_swr & ~swr_do;

  // Next values of the status bits
  wire next_lock  = data_byte[LOCK_POS];
  wire next_bp_lo = data_byte[BP_LO_POS];
  wire next_bp_hi = data_byte[BP_HI_POS];

  // Edge detector and toggle tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_d     <= 1'b1;
      tgl_seen <= 1'b0;
    end else begin
      cs_d <= cs_s;
      if (new_cmd) begin
        tgl_seen <= tgl_s;
      end
    end
  end

  // Arming lasts exactly one following command
  always_ff @(posedge clk) begin
    if (srst) begin
      arm <= 1'b0;
    end else if (new_cmd) begin
      arm <= is_arm;
    end
  end

  // Status bits; all three change together when allowed
  always_ff @(posedge clk) begin
    if (srst) begin
      protect_lock_bit     <= LOCK_RST;
      block_protect_bit_lo <= BP_RST[0];
      block_protect_bit_hi <= BP_RST[1];
    end else if (swr_do) begin
      // Lock may rise with new protect bits in one write
      protect_lock_bit     <= next_lock;
      block_protect_bit_lo <= next_bp_lo;
      block_protect_bit_hi <= next_bp_hi;
    end
  end

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------

  wire hit_status = (reg_addr == REG_STATUS);
  wire hit_accept = (reg_addr == REG_ACCEPT_CNT);
  wire hit_reject = (reg_addr == REG_REJECT_CNT);
  wire clr_accept = reg_wr & hit_accept & reg_wdata[0];
  wire clr_reject = reg_wr & hit_reject & reg_wdata[0];

  // Status word as software sees it
  flsl_data_t status_word;
  always_comb begin
    status_word = '0;
    status_word[ST_BP_LO_POS] = block_protect_bit_lo;
    status_word[ST_BP_HI_POS] = block_protect_bit_hi;
    status_word[ST_LOCK_POS]  = protect_lock_bit;
    status_word[ST_ARM_POS]   = arm;
    status_word[ST_WP_POS]    = wp_s;
    status_word[ST_SEL_POS]   = ~cs_s;
  end

  // Read mux; unmapped addresses read zero
  flsl_data_t next_rdata;
  always_comb begin
    if (!reg_rd) begin
      next_rdata = '0;
    end else if (hit_status) begin
      next_rdata = status_word;
    end else if (hit_accept) begin
      next_rdata = {{(DATA_W-CNT_W){1'b0}}, accept_cnt};
    end else if (hit_reject) begin
      next_rdata = {{(DATA_W-CNT_W){1'b0}}, reject_cnt};
    end else begin
      next_rdata = '0;
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Applied-write counter; an event together with a clear loads one
  always_ff @(posedge clk) begin
    if (srst) begin
      accept_cnt <= CNT_RST;
    end else if (swr_do) begin
      accept_cnt <= clr_accept ? CNT_W'(1) : accept_cnt + CNT_W'(1);
    end else if (clr_accept) begin
      accept_cnt <= CNT_RST;
    end
  end

  // Ignored-write counter; an event together with a clear loads one
  always_ff @(posedge clk) begin
    if (srst) begin
      reject_cnt <= CNT_RST;
    end else if (swr_refuse) begin
      reject_cnt <= clr_reject ? CNT_W'(1) : reject_cnt + CNT_W'(1);
    end else if (clr_reject) begin
      reject_cnt <= CNT_RST;
    end
  end

endmodule

//--- verif/flsl_host.sv
// Host model that frames commands on the serial link
`timescale 1ns/1ps
module flsl_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  localparam time HALF = 24ns; // Half of the 48 ns link period
  // Clock stands low and select high outside frames
  // A short select pulse at start; its rising end clears the link-side frame state
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    #1 cs_n = 1'b1;
  end
  // One frame: n bits MSB first from the top of bits, code bytes caught after bit 32
  task automatic frame(input logic [55:0] bits, input int n, output logic [15:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      si = bits[55-i];
      #HALF sck = 1'b1;
      if (i >= 32) rx = {rx[14:0], so & so_oe};
      #HALF sck = 1'b0;
    end
    #HALF cs_n = 1'b1;
    si = ~si; // Released line no longer shows the last bit
    #(5 * HALF);
  endtask
endmodule

//--- verif/flsl_top_properties.sv
// Checker for status-lock handling and the identify read
`timescale 1ns/1ps
module flsl_top_properties
  import flsl_pkg::*;
#(
  parameter flsl_byte_t MFR_CODE = 8'h00,
  parameter flsl_byte_t DEV_CODE = 8'h00
) (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 sck,
  input wire logic                 cs_n,
  input wire logic                 si,
  input wire logic                 wp_n_pin,
  input wire logic                 so,
  input wire logic                 so_oe,
  input wire logic                 protect_lock_bit,
  input wire logic                 block_protect_bit_lo,
  input wire logic                 block_protect_bit_hi
);
  logic [3:0]  hi_cnt;  // Clocks since select went high
  logic [3:0]  wpl_cnt; // Clocks with protect pin low
  logic [5:0]  ckn;     // Link clock rises in this frame
  logic [31:0] sr;      // Opcode and address as shifted in
  wire  [2:0]  st   = {protect_lock_bit, block_protect_bit_hi, block_protect_bit_lo};
  wire         idf  = (sr[31:24] == 8'h90) || (sr[31:24] == 8'hAB);
  wire  [5:0]  k    = ckn - 6'h20; // Output bit number
  wire  [7:0]  code = (sr[0] ^ k[3]) ? DEV_CODE : MFR_CODE;
  // Saturating cycle counters in the system domain
  always_ff @(posedge clk) begin
    if (srst) begin
      hi_cnt  <= 4'h0;
      wpl_cnt <= 4'h0;
    end else begin
      hi_cnt  <= cs_n ? hi_cnt + {3'h0, hi_cnt != 4'hF} : 4'h0;
      wpl_cnt <= wp_n_pin ? 4'h0 : wpl_cnt + {3'h0, wpl_cnt != 4'hF};
    end
  end
  // Frame bit count and header capture in the link domain
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      ckn <= 6'h00;
    end else begin
      ckn <= ckn + {5'h0, ckn != 6'h3F};
      if (!ckn[5]) sr <= {sr[30:0], si};
    end
  end
  property p_st_when;
    @(posedge clk) disable iff (srst) $changed(st) |-> hi_cnt inside {[2:6]};
  endproperty
  a_st_when: assert property (p_st_when) else $error("status moved outside end of frame");
  property p_locked;
    @(posedge clk) disable iff (srst) (wpl_cnt == 4'hF && $past(protect_lock_bit)) |-> $stable(st);
  endproperty
  a_locked: assert property (p_locked) else $error("locked status changed");
  property p_lock_fall;
    @(posedge clk) disable iff (srst) $fell(protect_lock_bit) |-> wpl_cnt == 4'h0;
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock cleared with pin low");
  property p_unsel;
    @(posedge clk) disable iff (srst) (cs_n && $past(cs_n)) |-> !so_oe && !so;
  endproperty
  a_unsel: assert property (p_unsel) else $error("output driven while deselected");
  property p_oe_cause;
    @(posedge sck) disable iff (cs_n) so_oe |-> ckn >= 6'h20 && idf;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("output enabled too early");
  property p_oe_on;
    @(posedge sck) disable iff (cs_n) (ckn >= 6'h20 && idf) |-> so_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("identify output not enabled");
  property p_so_first;
    @(posedge sck) disable iff (cs_n) (ckn >= 6'h20 && ckn < 6'h28 && idf) |-> so == code[~k[2:0]];
  endproperty
  a_so_first: assert property (p_so_first) else $error("first code bit wrong");
  property p_so_next;
    @(posedge sck) disable iff (cs_n) (ckn >= 6'h28 && ckn < 6'h3F && idf) |-> so == code[~k[2:0]];
  endproperty
  a_so_next: assert property (p_so_next) else $error("alternate code bit wrong");
  c_id: cover property (@(posedge sck) disable iff (cs_n) ckn == 6'h2F && idf);
  c_lkw: cover property (@(posedge clk) disable iff (srst) wpl_cnt == 4'hF && $rose(cs_n));
  c_fall: cover property (@(posedge clk) disable iff (srst) $fell(protect_lock_bit));
endmodule
bind flsl_top flsl_top_properties #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE)) flsl_props_inst (
  .clk, .srst, .sck, .cs_n, .si, .wp_n_pin, .so, .so_oe,
  .protect_lock_bit, .block_protect_bit_lo, .block_protect_bit_hi);

//--- verif/test_flsl_top.sv
// Self-checking bench for status-lock handling and the identify read
`timescale 1ns/1ps
module test_flsl_top;
  import flsl_pkg::*;
  localparam flsl_byte_t MFR = 8'h5A; // Arbitrary maker code
  localparam flsl_byte_t DEV = 8'hC3; // Arbitrary device code
  localparam flsl_byte_t ARM = 8'h50; // Status-write arm opcode
  localparam flsl_byte_t WRS = 8'h01; // Status-write opcode
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  flsl_addr_t reg_addr = '0;
  flsl_data_t reg_wdata = '0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       rd_d = 1'b0;     // Read answer due this cycle
  logic       wp_n_pin = 1'b0;
  flsl_data_t reg_rdata;
  logic       sck, cs_n, si, so, so_oe, lk_o, bh_o, bl_o;
  flsl_data_t expq[$];         // Expected read data
  flsl_data_t mskq[$];         // Bits that count in each read
  int         miscompares = 0;
  int         checks = 0;
  logic       lk = 0, bh = 0, bl = 0; // Expected status bits
  flsl_data_t acc = '0, rej = '0;     // Expected counters
  logic [15:0] rx;
  logic [31:0] rv;
  always #2.5 clk = ~clk;
  flsl_top #(.MFR_CODE(MFR), .DEV_CODE(DEV), .OPC_STATUS_ARM(ARM), .OPC_STATUS_WR(WRS))
    flsl_top_inst (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sck,
    .cs_n, .si, .wp_n_pin, .so, .so_oe, .protect_lock_bit(lk_o),
    .block_protect_bit_lo(bl_o), .block_protect_bit_hi(bh_o));
  flsl_host flsl_host_inst (.sck, .cs_n, .si, .so, .so_oe);
  task automatic chk(input flsl_data_t got, input flsl_data_t exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Watcher takes the oldest note when a read answer stands
  always @(posedge clk) begin
    if (rd_d) chk(reg_rdata & mskq.pop_front(), expq.pop_front());
    else if (!srst) chk(reg_rdata, '0); // Read data is zero outside the answer cycle
    rd_d <= reg_rd;
  end
  task automatic wr(input flsl_addr_t a, input flsl_data_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input flsl_addr_t a, input flsl_data_t e, input flsl_data_t m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(e);
    mskq.push_back(m);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // Status bits at the ports and in the register, then both counters
  task automatic st_chk();
    repeat (10) @(posedge clk);
    chk({29'h0, lk_o, bh_o, bl_o}, {29'h0, lk, bh, bl});
    rd(REG_STATUS, {26'h0, 1'b0, wp_n_pin, 1'b0, lk, bh, bl}, 32'h3F);
    rd(REG_ACCEPT_CNT, acc, '1);
    rd(REG_REJECT_CNT, rej, '1);
  endtask
  // Status write, armed or not, with the expected outcome worked out here
  task automatic sw(input flsl_byte_t d, input logic arm);
    if (arm) flsl_host_inst.frame({ARM, 48'h0}, 8, rx);
    flsl_host_inst.frame({WRS, d, 40'h0}, 16, rx);
    if (arm && (wp_n_pin || !lk)) begin
      {lk, bh, bl} = {d[7], d[3], d[2]};
      acc++;
    end else begin
      rej++;
    end
    st_chk();
  endtask
  // Identify read of two code bytes with a random upper address
  task automatic idr(input flsl_byte_t op, input logic a0);
    rv = $urandom();
    flsl_host_inst.frame({op, rv[22:0], a0, 24'h0}, 48, rx);
    chk({16'h0, rx}, {16'h0, a0 ? {DEV, MFR} : {MFR, DEV}});
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rv = $urandom(32'h5285);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (PU_WAIT_CYC) @(posedge clk);
    wr(REG_STATUS, '1); // Read-only status ignores writes
    st_chk();
    rd(8'h0C, '0, '1); // Unmapped place reads zero
    sw(8'h8C, 1'b0);
    flsl_host_inst.frame({ARM, 48'h0}, 8, rx);
    idr(OPC_IDENT_A, 1'b1); // Another command discards the arming
    sw(8'h8C, 1'b0);
    sw(8'h8C, 1'b1);
    sw(8'h00, 1'b1);
    wp_n_pin <= 1'b1;
    sw(8'h00, 1'b1);
    repeat (4) sw(flsl_byte_t'($urandom()), 1'b1);
    sw(8'h84, 1'b1);
    wp_n_pin <= 1'b0;
    sw(8'h08, 1'b1);
    for (int i = 0; i < 4; i++) idr(i[1] ? OPC_IDENT_B : OPC_IDENT_A, i[0]);
    wr(REG_ACCEPT_CNT, 32'h1); // Counter clear
    acc = '0;
    wr(REG_REJECT_CNT, 32'h1); // Counter clear
    rej = '0;
    st_chk();
    sw(8'h08, 1'b1);
    srst <= 1'b1; // Mid-run reset
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    {lk, bh, bl} = 3'h0;
    rej = '0;
    st_chk();
    close_out();
  end
endmodule
